// ===== design/clk_ctrl_pkg.sv
// constants, field layouts and types for the clock and power controller
// assumes a 20 MHz system clock and a 32-bit apb register bus
package clk_ctrl_pkg;
  localparam int          CLK_HZ          = 20_000_000;
  localparam int          LOCK_MIN_NS     = 150_000;
  localparam int          LOCK_MIN_CYC    =
    (LOCK_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0]  ADDR_MPLL_CFG   = 8'h00;
  localparam logic [7:0]  ADDR_UPLL_CFG   = 8'h04;
  localparam logic [7:0]  ADDR_LOCK_CNT   = 8'h08;
  localparam logic [7:0]  ADDR_GATE       = 8'h0c;
  localparam logic [7:0]  ADDR_MODE       = 8'h10;
  localparam logic [7:0]  ADDR_DIV        = 8'h14;
  localparam logic [7:0]  ADDR_STATUS     = 8'h18;
  localparam logic [7:0]  ADDR_FREQ       = 8'h1c;
  localparam logic [19:0] PLL_CFG_RST     = 20'h5c040;
  localparam logic [11:0] LOCK_CNT_RST    = 12'hfff;
  localparam logic [15:0] GATE_RST        = 16'hffff;
  localparam logic [7:0]  M_OFFSET        = 8'h08;
  localparam logic [5:0]  P_OFFSET        = 6'h02;
  localparam int          M_LSB           = 12;
  localparam int          P_LSB           = 4;
  localparam int          S_LSB           = 0;
  localparam int          LCNT_U_LSB      = 12;
  localparam logic [1:0]  TEST_LOW_CODE   = 2'h3;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

  typedef enum logic [2:0] {
    PM_NORMAL, PM_SLOW, PM_IDLE, PM_STOP, PM_LCD_IDLE
  } pm_mode_t;

  typedef enum {LK_BYPASS, LK_LOCKING, LK_LOCKED} lock_state_t;

  typedef struct packed {
    logic [7:0] m;
    logic [5:0] p;
    logic [1:0] s;
  } pll_div_t;

  typedef struct packed {
    logic core;
    logic hbus;
    logic pbus;
    logic lcd;
    logic usb;
  } clk_en_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage : clk_ctrl_pkg

// ===== design/clk_ctrl.sv
// clock control: boot source select, pll lock timing, clock enables, modes
// assumes the analog plls and gate cells sit outside; all inputs but arst_n_in are
// synchronous to clock_in; outputs are enables for glitch-free gate cells
// Operation
// - latch boot clock pins at reset release
// - mode code picks main and usb source
// - pll unused until config register written
// - low pins 11 make upper pins test
// - pll output m*fin/(p*2^s), offsets 8, 2
// - usb pll behaves like the main pll; here it gets no lock interval after reset, and on wake only once in use
// - core source: pll or direct input
// - new frequency holds core clock until lock
// - lock interval after reset and wake-up
// - interval is count times input period
// - relock only on write; switch at end
// - no internal clocks during relock; here main pll relock stops core, bus and lcd but the usb clock keeps running
// - slow mode drives core from input
// - idle stops core; interrupt wakes
// - stop disables plls; pin or alarm wakes
// - lcd-only idle keeps lcd clock only
// - core, bus clocks and per-block gating
// - usb pll dedicated to 48 mhz clock
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/10ps
module clk_ctrl #(
  parameter int N_GATES   = 16,
  parameter int LOCK_BITS = 12
) (
  input  wire logic                   clock_in,
  input  wire logic                   arst_n_in,
  input  wire logic [1:0]             boot_clock_mode_pins_in,
  input  wire logic [1:0]             boot_mode_low_pins_in,
  input  wire logic                   irq_in,
  input  wire logic                   ext_wake_in,
  input  wire logic                   rtc_alarm_in,
  input  wire clk_ctrl_pkg::apb_req_t apb_in,
  output logic [31:0]                 prdata_out,
  output logic                        pready_out,
  output logic                        pslverr_out,
  output logic                        main_src_ext_out,
  output logic                        usb_src_ext_out,
  output logic                        test_mode_out,
  output logic [1:0]                  test_sel_out,
  output logic                        core_sel_pll_out,
  output logic                        usb_sel_pll_out,
  output logic                        mpll_on_out,
  output logic                        upll_on_out,
  output clk_ctrl_pkg::pll_div_t      mpll_div_out,
  output clk_ctrl_pkg::pll_div_t      upll_div_out,
  output clk_ctrl_pkg::clk_en_t       clk_en_out,
  output logic                        hclk_half_out,
  output logic [1:0]                  pclk_div_out,
  output logic [N_GATES-1:0]          periph_en_out
);
  import clk_ctrl_pkg::*;

  initial begin
    if (N_GATES < 1 || N_GATES > 32) $error("N_GATES out of range");
    if (LOCK_BITS < 8 || LOCK_BITS > 16) $error("LOCK_BITS out of range");
  end

  // reset release through two flip-flops
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // boot straps are caught on the first clock after release
  logic       strap_done_reg;
  logic [1:0] clk_mode_reg;
  logic [1:0] low_mode_reg;
  always_ff @(posedge clock_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      strap_done_reg <= 1'b0;
      clk_mode_reg   <= 2'h0;
      low_mode_reg   <= 2'h0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      clk_mode_reg   <= boot_clock_mode_pins_in;
      low_mode_reg   <= boot_mode_low_pins_in;
    end
  end

  // apb decode
  wire       wr_en   = apb_in.psel & apb_in.penable & apb_in.pwrite;
  wire       rd_en   = apb_in.psel & apb_in.penable & ~apb_in.pwrite;
  wire [7:0] addr    = apb_in.paddr;
  wire       hit_mcf = addr == ADDR_MPLL_CFG;
  wire       hit_ucf = addr == ADDR_UPLL_CFG;
  wire       hit_lck = addr == ADDR_LOCK_CNT;
  wire       hit_gat = addr == ADDR_GATE;
  wire       hit_mod = addr == ADDR_MODE;
  wire       hit_div = addr == ADDR_DIV;
  wire       hit_sts = addr == ADDR_STATUS;
  wire       hit_frq = addr == ADDR_FREQ;
  wire       mapped  = hit_mcf | hit_ucf | hit_lck | hit_gat | hit_mod |
                       hit_div | hit_sts | hit_frq;

  logic [19:0]          mpll_cfg_reg;
  logic [19:0]          upll_cfg_reg;
  logic [2*LOCK_BITS-1:0] lock_cnt_reg;
  logic [N_GATES-1:0]   gate_reg;
  pm_mode_t             mode_reg;
  logic [1:0]           div_reg;
  logic [LOCK_BITS-1:0] mcnt_reg;
  logic [LOCK_BITS-1:0] ucnt_reg;
  lock_state_t          mst_reg;
  lock_state_t          ust_reg;
  logic                 wake_lock_reg;

  wire wr_mcf = wr_en & hit_mcf;
  wire wr_ucf = wr_en & hit_ucf;
  wire wr_mod = wr_en & hit_mod;

  // wake-up from idle, stop or lcd-only idle
  wire deep_sleep = (mode_reg == PM_STOP) | (mode_reg == PM_LCD_IDLE);
  wire wake_deep  = deep_sleep & (ext_wake_in | rtc_alarm_in);
  wire wake_idle  = (mode_reg == PM_IDLE) & irq_in;

  pm_mode_t mode_next;
  always_comb begin
    mode_next = mode_reg;
    if (wake_deep || wake_idle) begin
      mode_next = PM_NORMAL;
    end else if (wr_mod) begin
      case (apb_in.pwdata[2:0])
        3'h0:    mode_next = PM_NORMAL;
        3'h1:    mode_next = PM_SLOW;
        3'h2:    mode_next = PM_IDLE;
        3'h3:    mode_next = PM_STOP;
        3'h4:    mode_next = PM_LCD_IDLE;
        default: mode_next = mode_reg;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mpll_cfg_reg <= PLL_CFG_RST;
      upll_cfg_reg <= PLL_CFG_RST;
      lock_cnt_reg <= (2*LOCK_BITS)'({LOCK_CNT_RST, LOCK_CNT_RST});
      gate_reg     <= GATE_RST[N_GATES-1:0];
      mode_reg     <= PM_NORMAL;
      div_reg      <= 2'h0;
    end else begin
      if (wr_mcf) mpll_cfg_reg <= apb_in.pwdata[19:0];
      if (wr_ucf) upll_cfg_reg <= apb_in.pwdata[19:0];
      if (wr_en && hit_lck) lock_cnt_reg <= apb_in.pwdata[2*LOCK_BITS-1:0];
      if (wr_en && hit_gat) gate_reg <= apb_in.pwdata[N_GATES-1:0];
      if (wr_en && hit_div) div_reg <= apb_in.pwdata[1:0];
      mode_reg <= mode_next;
    end
  end

  wire [LOCK_BITS-1:0] m_load = lock_cnt_reg[LOCK_BITS-1:0];
  wire [LOCK_BITS-1:0] u_load = lock_cnt_reg[2*LOCK_BITS-1:LOCK_BITS];

  // deep wake re-runs the lock timing on the main pll, and on the usb pll only once in use
  always_ff @(posedge clock_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wake_lock_reg <= 1'b0;
    end else begin
      wake_lock_reg <= wake_deep;
    end
  end

  // one lock sequencer per pll, identical for usb
  function automatic lock_state_t lk_next(
    input lock_state_t st, input logic wr, input logic wake,
    input logic [LOCK_BITS-1:0] cnt);
    lock_state_t r;
    r = st;
    case (st)
      LK_BYPASS:  if (wr) r = LK_LOCKING;
      LK_LOCKING: if (wr) r = LK_LOCKING;
                  else if (cnt == '0) r = LK_LOCKED;
      LK_LOCKED:  if (wr || wake) r = LK_LOCKING;
      default:    r = LK_BYPASS;
    endcase
    return r;
  endfunction : lk_next

  // deep wake times the main pll lock even before it is switched in; the usb pll only once in use
  wire m_start = wr_mcf | wake_lock_reg;
  wire u_start = wr_ucf | (wake_lock_reg & ust_reg != LK_BYPASS);

  always_ff @(posedge clock_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      mst_reg  <= LK_BYPASS;
      ust_reg  <= LK_BYPASS;
      // power-on lock: core stays off until the reset count has run out
      mcnt_reg <= LOCK_BITS'(LOCK_CNT_RST);
      ucnt_reg <= '0;
    end else begin
      mst_reg <= lk_next(mst_reg, wr_mcf, wake_lock_reg, mcnt_reg);
      ust_reg <= lk_next(ust_reg, wr_ucf, wake_lock_reg, ucnt_reg);
      if (m_start) mcnt_reg <= m_load;
      else if (mcnt_reg != '0) mcnt_reg <= mcnt_reg - 1'b1;
      if (u_start) ucnt_reg <= u_load;
      else if (ucnt_reg != '0) ucnt_reg <= ucnt_reg - 1'b1;
    end
  end

  // clock enables per mode; gate cells switch on low clock phase
  wire m_lock  = mst_reg == LK_LOCKING;
  wire m_ok    = ~m_lock & ~wake_lock_reg & (mcnt_reg == '0);
  wire is_norm = (mode_reg == PM_NORMAL) | (mode_reg == PM_SLOW);
  wire is_idle = mode_reg == PM_IDLE;
  wire is_lcdi = mode_reg == PM_LCD_IDLE;
  wire en_core = m_ok & is_norm;
  wire en_bus  = m_ok & (is_norm | is_idle);
  wire en_lcd  = m_ok & (is_norm | is_idle | is_lcdi);
  wire en_usb  = ~deep_sleep & (ust_reg != LK_LOCKING);
  wire sel_pll = (mst_reg == LK_LOCKED) & (mode_reg != PM_SLOW);
  wire plls_on = ~deep_sleep;

  logic [N_GATES-1:0] periph_next;
  genvar g;
  generate
    for (g = 0; g < N_GATES; g++) begin : gen_gate
      assign periph_next[g] = gate_reg[g] & en_bus & ~is_lcdi;
    end
  endgenerate

  // read mux: status shows lock state and straps
  wire [31:0] status = {16'h0, 4'h0, low_mode_reg, clk_mode_reg,
                        1'b0, mode_reg, (ust_reg == LK_LOCKED),
                        (mst_reg == LK_LOCKED), m_lock, (ust_reg == LK_LOCKING)};
  // pll ratio terms: m and p*2^s so software can check the ratio
  wire [7:0]  m_fld  = mpll_cfg_reg[M_LSB +: 8];
  wire [5:0]  p_fld  = mpll_cfg_reg[P_LSB +: 6];
  wire [1:0]  s_fld  = mpll_cfg_reg[S_LSB +: 2];
  wire [8:0]  m_val  = {1'b0, m_fld} + {1'b0, M_OFFSET};
  wire [6:0]  p_val  = {1'b0, p_fld} + {1'b0, P_OFFSET};
  wire [9:0]  p_den  = {3'h0, p_val} << s_fld;
  wire [31:0] freq   = {6'h0, p_den, 7'h0, m_val};
  wire [31:0] rd_mux =
    hit_mcf ? {12'h0, mpll_cfg_reg} :
    hit_ucf ? {12'h0, upll_cfg_reg} :
    hit_lck ? 32'(lock_cnt_reg) :
    hit_gat ? 32'(gate_reg) :
    hit_mod ? 32'(mode_reg) :
    hit_div ? {30'h0, div_reg} :
    hit_sts ? status :
    hit_frq ? freq : UNMAPPED_DATA;

  always_ff @(posedge clock_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      prdata_out       <= '0;
      pready_out       <= 1'b0;
      pslverr_out      <= 1'b0;
      main_src_ext_out <= 1'b0;
      usb_src_ext_out  <= 1'b0;
      test_mode_out    <= 1'b0;
      test_sel_out     <= 2'h0;
      core_sel_pll_out <= 1'b0;
      usb_sel_pll_out  <= 1'b0;
      mpll_on_out      <= 1'b1;
      upll_on_out      <= 1'b1;
      mpll_div_out     <= '0;
      upll_div_out     <= '0;
      clk_en_out       <= '0;
      hclk_half_out    <= 1'b0;
      pclk_div_out     <= 2'h0;
      periph_en_out    <= '0;
    end else begin
      // apb answers in the setup-to-access cycle: zero wait states
      pready_out       <= apb_in.psel & ~apb_in.penable;
      pslverr_out      <= apb_in.psel & ~apb_in.penable & ~mapped;
      prdata_out       <= (apb_in.psel & ~apb_in.pwrite) ? rd_mux : '0;
      main_src_ext_out <= clk_mode_reg[1];
      usb_src_ext_out  <= clk_mode_reg[0];
      test_mode_out    <= strap_done_reg & (low_mode_reg == TEST_LOW_CODE);
      test_sel_out     <= clk_mode_reg;
      core_sel_pll_out <= sel_pll;
      usb_sel_pll_out  <= ust_reg == LK_LOCKED;
      mpll_on_out      <= plls_on;
      upll_on_out      <= plls_on;
      mpll_div_out     <= {m_fld, p_fld, s_fld};
      upll_div_out     <= {upll_cfg_reg[M_LSB +: 8], upll_cfg_reg[P_LSB +: 6],
                           upll_cfg_reg[S_LSB +: 2]};
      clk_en_out       <= {en_core, en_bus, en_bus, en_lcd, en_usb};
      hclk_half_out    <= div_reg[1];
      pclk_div_out     <= div_reg;
      periph_en_out    <= periph_next;
    end
  end
  // rd_en kept for decode symmetry: reads have no side effects
  wire unused_rd = rd_en;
endmodule : clk_ctrl

// ===== dv/clk_ctrl_chk.sv
// checker for the clock controller, bound to its top module
// sees top ports only; helper flags mirror software writes and wakes
`timescale 1ns/10ps
module clk_ctrl_chk (
  input wire logic                   clock_in,
  input wire logic                   arst_n_in,
  input wire logic                   irq_in,
  input wire logic                   ext_wake_in,
  input wire logic                   rtc_alarm_in,
  input wire clk_ctrl_pkg::apb_req_t apb_in,
  input wire logic                   pready_out,
  input wire logic                   main_src_ext_out,
  input wire logic                   usb_src_ext_out,
  input wire logic                   test_mode_out,
  input wire logic [1:0]             test_sel_out,
  input wire logic                   core_sel_pll_out,
  input wire logic                   usb_sel_pll_out,
  input wire logic                   mpll_on_out,
  input wire logic                   upll_on_out,
  input wire clk_ctrl_pkg::clk_en_t  clk_en_out
);
  import clk_ctrl_pkg::*;
  logic [2:0] up_reg, pm_reg, old_reg, pm_next;
  logic       mseen_reg, useen_reg;
  wire acc = apb_in.psel & apb_in.penable & pready_out & apb_in.pwrite;
  wire wr_m = acc & (apb_in.paddr == ADDR_MPLL_CFG);
  wire wr_u = acc & (apb_in.paddr == ADDR_UPLL_CFG);
  wire wr_pm = acc & (apb_in.paddr == ADDR_MODE);
  wire stop_like = (pm_reg == PM_STOP) | (pm_reg == PM_LCD_IDLE);
  // wake wins over a mode write in the same cycle, as in the design
  wire wake = irq_in & (pm_reg == PM_IDLE) |
              (ext_wake_in | rtc_alarm_in) & stop_like;
  assign pm_next = wake ? 3'h0 : wr_pm ? apb_in.pwdata[2:0] : pm_reg;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      up_reg    <= 3'h0;
      pm_reg    <= 3'h0;
      old_reg   <= 3'h0;
      mseen_reg <= 1'b0;
      useen_reg <= 1'b0;
    end else begin
      up_reg    <= up_reg + {2'h0, up_reg != 3'h6};
      pm_reg    <= pm_next;
      old_reg   <= pm_reg;
      mseen_reg <= mseen_reg | wr_m;
      useen_reg <= useen_reg | wr_u;
    end
  end
  src_map_a:
    assert property ({main_src_ext_out, usb_src_ext_out} == test_sel_out)
    else $error("source select differs from straps");
  strap_hold_a:
    assert property (up_reg == 3'h6 |->
      $stable(test_sel_out) && $stable(test_mode_out))
    else $error("latched straps changed");
  no_early_a:
    assert property (!mseen_reg |-> !core_sel_pll_out)
    else $error("core on pll before config write");
  usb_early_a:
    assert property (!useen_reg |-> !usb_sel_pll_out)
    else $error("usb on pll before config write");
  relock_gate_a:
    assert property (wr_m |-> ##2 clk_en_out[4:1] == 4'h0)
    else $error("clocks run during relock");
  slow_src_a:
    assert property (pm_reg == PM_SLOW && old_reg == PM_SLOW |->
      !core_sel_pll_out)
    else $error("slow mode core not on input");
  idle_core_a:
    assert property (pm_reg == PM_IDLE && old_reg == PM_IDLE |->
      clk_en_out[4:2] == 3'h3)
    else $error("idle enables wrong");
  stop_frz_a:
    assert property (pm_reg == PM_STOP && old_reg == PM_STOP |->
      clk_en_out == '0 && !mpll_on_out && !upll_on_out)
    else $error("stop mode clocks or plls on");
  lcd_only_a:
    assert property (pm_reg == PM_LCD_IDLE && old_reg == PM_LCD_IDLE |->
      clk_en_out[4:1] == 4'h1)
    else $error("lcd idle enables wrong");
endmodule : clk_ctrl_chk
bind clk_ctrl clk_ctrl_chk clk_ctrl_chk_i (.*);

// ===== dv/clk_ctrl_tb.sv
// self-checking bench for the clock controller
// bench is apb master, strap source and wake source; checker is bound
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module clk_ctrl_tb;
  import clk_ctrl_pkg::*;
  logic        clock_in, arst_n_in, irq_in, ext_wake_in, rtc_alarm_in;
  logic [1:0]  boot_clock_mode_pins_in, boot_mode_low_pins_in;
  logic [1:0]  test_sel_out, pclk_div_out;
  logic [31:0] prdata_out, q, d;
  logic        pready_out, pslverr_out, main_src_ext_out, err_q;
  logic        usb_src_ext_out, test_mode_out, core_sel_pll_out;
  logic        usb_sel_pll_out, mpll_on_out, upll_on_out, hclk_half_out;
  logic [15:0] periph_en_out;
  logic [7:0]  m;
  logic [5:0]  p;
  logic [1:0]  s;
  logic [4:0]  exp_tab [1:4] = '{5'h1f, 5'h0f, 5'h00, 5'h02};
  logic [2:0]  wake_tab [1:4] = '{3'h0, 3'h4, 3'h2, 3'h1};
  apb_req_t    apb_in;
  pll_div_t    mpll_div_out, upll_div_out;
  clk_en_t     clk_en_out;
  int          num_errors, n_checks, n, seed;

  clk_ctrl clk_ctrl_i (.*);

  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    k = 0;
    apb_in <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clock_in);
    apb_in.penable <= 1'b1;
    do @(posedge clock_in); while (pready_out !== 1'b1 && k++ < 50);
    if (k > 50) num_errors++;
    q = prdata_out;
    err_q = pslverr_out;
    apb_in <= '0;
    @(posedge clock_in);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask : rd

  // cycles the core clock stays off, counted from its fall
  task automatic lock_len();
    int k;
    k = 0;
    n = 0;
    while (clk_en_out.core !== 1'b0 && k++ < 8) @(posedge clock_in);
    while (clk_en_out.core !== 1'b1 && n < 9000) begin
      @(posedge clock_in);
      n++;
    end
  endtask : lock_len

  task automatic results();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial begin
    repeat (40000) @(posedge clock_in);
    num_errors++;
    results();
  end

  initial begin
    seed = 32'h0833;
    {irq_in, ext_wake_in, rtc_alarm_in} = 3'h0;
    apb_in = '0;
    // last pass leaves straps at 00 so later tests run out of test mode
    for (int i = 3; i >= 0; i--) begin
      boot_clock_mode_pins_in <= 2'(i);
      boot_mode_low_pins_in <= 2'(i);
      arst_n_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      arst_n_in <= 1'b1;
      repeat (6) @(posedge clock_in);
      boot_clock_mode_pins_in <= ~2'(i);
      @(posedge clock_in);
      `CHK(test_sel_out, 2'(i))
      `CHK({main_src_ext_out, usb_src_ext_out}, 2'(i))
      `CHK(test_mode_out, (i == 3))
      `CHK({core_sel_pll_out, mpll_on_out, upll_on_out}, 3'h3)
      rd(ADDR_MPLL_CFG, 32'(PLL_CFG_RST));
      rd(ADDR_GATE, 32'(GATE_RST));
    end
    lock_len();
    `CHK(n > 4000, 1'b1)
    $display("strap and reset test done");
    d = {8'h0, 12'(LOCK_MIN_CYC), 12'(LOCK_MIN_CYC)};
    apb(1'b1, ADDR_LOCK_CNT, d);
    rd(ADDR_LOCK_CNT, d);
    m = 8'($random(seed));
    p = 6'($random(seed));
    s = 2'($random(seed));
    apb(1'b1, ADDR_MPLL_CFG, {12'h0, m, 2'h0, p, 2'h0, s});
    lock_len();
    `CHK(n, LOCK_MIN_CYC + 1)
    `CHK({core_sel_pll_out, mpll_div_out}, {1'b1, m, p, s})
    d = ((32'(p) + 32'h2) << s) << 16 | (32'(m) + 32'h8);
    rd(ADDR_FREQ, d);
    apb(1'b1, ADDR_UPLL_CFG, {12'h0, m, 2'h0, p, 2'h0, s});
    n = 0;
    while (usb_sel_pll_out !== 1'b1 && n++ < 9000) @(posedge clock_in);
    `CHK(n >= LOCK_MIN_CYC, 1'b1)
    `CHK(upll_div_out, {m, p, s})
    $display("pll lock test done");
    for (int md = 1; md < 5; md++) begin
      apb(1'b1, ADDR_MODE, 32'(md));
      repeat (2) @(posedge clock_in);
      `CHK({clk_en_out[4:1], mpll_on_out}, exp_tab[md])
      if (md == 1) begin
        `CHK(core_sel_pll_out, 1'b0)
        apb(1'b1, ADDR_MODE, 32'h0);
      end else begin
        {irq_in, ext_wake_in, rtc_alarm_in} <= wake_tab[md];
        @(posedge clock_in);
        {irq_in, ext_wake_in, rtc_alarm_in} <= 3'h0;
      end
      lock_len();
      `CHK(n >= LOCK_MIN_CYC, md > 2)
      `CHK({core_sel_pll_out, mpll_on_out}, 2'h3)
    end
    $display("power mode test done");
    d = $random(seed);
    apb(1'b1, ADDR_GATE, d);
    @(posedge clock_in);
    `CHK(periph_en_out, d[15:0])
    apb(1'b1, ADDR_DIV, 32'h3);
    @(posedge clock_in);
    `CHK({hclk_half_out, pclk_div_out}, 3'h7)
    rd(ADDR_GATE, {16'h0, d[15:0]});
    rd(8'h20, UNMAPPED_DATA);
    `CHK(err_q, 1'b1)
    $display("gate test done");
    results();
  end
endmodule : clk_ctrl_tb
